// file: logic/mdt_pkg.sv
package mdt_pkg;

	localparam int DATA_W = 32;
	localparam int REG_N  = 32;
	localparam int DEST_W = 5;
	localparam int CNT_W  = 6;
	localparam int SLOT_N = 2;

	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

	// result latency, clocks from issue to result
	localparam logic [CNT_W-1:0] LAT_MUL_FULL  = 6'h05;
	localparam logic [CNT_W-1:0] LAT_MUL_SHORT = 6'h03;
	localparam logic [CNT_W-1:0] LAT_EMUL_FULL = 6'h06;
	localparam logic [CNT_W-1:0] LAT_DIVS      = 6'h25;
	localparam logic [CNT_W-1:0] LAT_DIV       = 6'h24;

	// back-to-back throughput, overflow mask flag set
	localparam logic [CNT_W-1:0] TPM_MUL_FULL  = 6'h04;
	localparam logic [CNT_W-1:0] TPM_MUL_SHORT = 6'h02;
	localparam logic [CNT_W-1:0] TPM_EMUL_FULL = 6'h05;

	// back-to-back throughput, overflow mask flag clear
	localparam logic [CNT_W-1:0] TPF_MULS_FULL = 6'h05;
	localparam logic [CNT_W-1:0] TPF_MULU_FULL = 6'h04;
	localparam logic [CNT_W-1:0] TPF_EMUL_FULL = 6'h06;
	localparam logic [CNT_W-1:0] TPF_MUL_SHORT = 6'h03;

	// divide class, either flag value
	localparam logic [CNT_W-1:0] TP_DIVS = 6'h24;
	localparam logic [CNT_W-1:0] TP_DIV  = 6'h23;

	// scheduler issue clocks per operation
	localparam int ISSUE_MUL  = 1;
	localparam int ISSUE_DIVS = 13;
	localparam int ISSUE_DIV  = 3;

	typedef enum logic [3:0] {
		OP_MULS = 4'h0,
		OP_MULU = 4'h1,
		OP_EMUL = 4'h2,
		OP_DIVS = 4'h3,
		OP_DIVU = 4'h4,
		OP_EDIV = 4'h5,
		OP_REMS = 4'h6,
		OP_REMU = 4'h7,
		OP_MODS = 4'h8
	} mdt_op_t;

	typedef struct packed {
		logic              valid;
		mdt_op_t           op;
		logic [DEST_W-1:0] dest;
	} mdt_issue_t;

	typedef struct packed {
		logic              valid;
		logic [DEST_W-1:0] dest;
		logic [DATA_W-1:0] hi;
		logic [DATA_W-1:0] lo;
		logic              overflow;
		logic              div_zero;
	} mdt_result_t;

	typedef struct packed {
		logic             busy;
		logic [CNT_W-1:0] cnt;
		mdt_result_t      res;
	} mdt_slot_t;

endpackage

// file: logic/mdt_arith.sv
`timescale 1ns/1ps

module mdt_arith (
	input  wire mdt_pkg::mdt_op_t op_in,
	input  wire logic [31:0]      a_in,
	input  wire logic [31:0]      b_in,
	input  wire logic [31:0]      hi_in,
	output logic      [31:0]      hi_out,
	output logic      [31:0]      lo_out,
	output logic                  overflow_out,
	output logic                  div_zero_out,
	output logic                  short_out
);

	logic signed [63:0] a_sx;
	logic signed [63:0] b_sx;
	logic signed [63:0] prod_s;
	logic        [63:0] prod_u;
	logic        [31:0] b_safe;
	logic signed [31:0] q_s;
	logic signed [31:0] r_s;
	logic        [31:0] q_u;
	logic        [31:0] r_u;
	logic        [63:0] q_x;
	logic        [63:0] r_x;
	logic        [31:0] mod_s;
	logic               div_min;
	logic               short_s;
	logic               short_u;

	assign a_sx    = {{32{a_in[31]}}, a_in};
	assign b_sx    = {{32{b_in[31]}}, b_in};
	assign prod_s  = a_sx * b_sx;
	assign prod_u  = {32'h0000_0000, a_in} * {32'h0000_0000, b_in};
	assign b_safe  = (b_in == 32'h0000_0000) ? 32'h0000_0001 : b_in;
	assign div_min = (a_in == 32'h8000_0000) && (b_in == 32'hFFFF_FFFF);
	assign q_s     = div_min ? $signed(a_in) : $signed(a_in) / $signed(b_safe);
	assign r_s     = div_min ? 32'sh0 : $signed(a_in) % $signed(b_safe);
	assign q_u     = a_in / b_safe;
	assign r_u     = a_in % b_safe;
	assign q_x     = {hi_in, a_in} / {32'h0000_0000, b_safe};
	assign r_x     = {hi_in, a_in} % {32'h0000_0000, b_safe};
	assign mod_s   = ((r_s != 32'sh0) && (r_s[31] != b_in[31]))
	               ? 32'(r_s + $signed(b_in)) : r_s;

	// operand fits in 16 bits
	assign short_s = (a_in[31:15] == {17{a_in[31]}})
	              || (b_in[31:15] == {17{b_in[31]}});
	assign short_u = (a_in[31:16] == 16'h0000) || (b_in[31:16] == 16'h0000);

	always_comb begin
		hi_out       = 32'h0000_0000;
		lo_out       = 32'h0000_0000;
		overflow_out = 1'b0;
		div_zero_out = 1'b0;
		short_out    = 1'b0;
		case (op_in)
			mdt_pkg::OP_MULS: begin
				lo_out       = prod_s[31:0];
				overflow_out = prod_s[63:31] != {33{prod_s[31]}};
				short_out    = short_s;
			end
			mdt_pkg::OP_MULU: begin
				lo_out       = prod_u[31:0];
				overflow_out = prod_u[63:32] != 32'h0000_0000;
				short_out    = short_u;
			end
			mdt_pkg::OP_EMUL: begin
				hi_out    = prod_u[63:32];
				lo_out    = prod_u[31:0];
				short_out = short_u;
			end
			mdt_pkg::OP_DIVS: begin
				lo_out       = q_s;
				overflow_out = div_min;
				div_zero_out = b_in == 32'h0000_0000;
			end
			mdt_pkg::OP_DIVU: begin
				lo_out       = q_u;
				div_zero_out = b_in == 32'h0000_0000;
			end
			mdt_pkg::OP_EDIV: begin
				hi_out       = r_x[31:0];
				lo_out       = q_x[31:0];
				overflow_out = q_x[63:32] != 32'h0000_0000;
				div_zero_out = b_in == 32'h0000_0000;
			end
			mdt_pkg::OP_REMS: begin
				lo_out       = r_s;
				div_zero_out = b_in == 32'h0000_0000;
			end
			mdt_pkg::OP_REMU: begin
				lo_out       = r_u;
				div_zero_out = b_in == 32'h0000_0000;
			end
			mdt_pkg::OP_MODS: begin
				lo_out       = mod_s;
				div_zero_out = b_in == 32'h0000_0000;
			end
			default: begin
				lo_out = 32'h0000_0000;
			end
		endcase
	end

endmodule

// file: logic/mdt_unit.sv
`timescale 1ns/1ps

module mdt_unit (
	input  wire logic                  clock_in,
	input  wire logic                  reset_in,
	input  wire mdt_pkg::mdt_issue_t   issue_in,
	input  wire logic [31:0]           first_operand_bus_in,
	input  wire logic [31:0]           second_operand_bus_in,
	input  wire logic [31:0]           high_operand_bus_in,
	input  wire logic                  overflow_mask_flag_in,
	output mdt_pkg::mdt_result_t       result_out,
	output logic                       busy_out,
	output logic [31:0]                scoreboard_out
);

	////////////////////////////////////////////////////////////////////////
	// arithmetic and operation decode

	logic [31:0]                   ar_hi;
	logic [31:0]                   ar_lo;
	logic                          ar_ovf;
	logic                          ar_dz;
	logic                          ar_short;
	wire                           accept;
	wire                           is_muls;
	wire                           is_mulu;
	wire                           is_emul;
	wire                           is_divs;
	wire                           is_mul;
	wire                           mul_short;
	wire  [mdt_pkg::CNT_W-1:0]     lat_sel;
	wire  [mdt_pkg::CNT_W-1:0]     tpm_sel;
	wire  [mdt_pkg::CNT_W-1:0]     tpf_sel;
	wire  [mdt_pkg::CNT_W-1:0]     tp_sel;

	mdt_arith u_arith (
		.op_in        (issue_in.op),
		.a_in         (first_operand_bus_in),
		.b_in         (second_operand_bus_in),
		.hi_in        (high_operand_bus_in),
		.hi_out       (ar_hi),
		.lo_out       (ar_lo),
		.overflow_out (ar_ovf),
		.div_zero_out (ar_dz),
		.short_out    (ar_short)
	);

	assign accept    = issue_in.valid && !busy_out;
	assign is_muls   = issue_in.op == mdt_pkg::OP_MULS;
	assign is_mulu   = issue_in.op == mdt_pkg::OP_MULU;
	assign is_emul   = issue_in.op == mdt_pkg::OP_EMUL;
	assign is_divs   = issue_in.op == mdt_pkg::OP_DIVS;
	assign is_mul    = is_muls || is_mulu || is_emul;
	// short timing only on 16-bit operand
	assign mul_short = is_mul && ar_short;

	assign lat_sel = mul_short          ? mdt_pkg::LAT_MUL_SHORT :
	                 (is_muls||is_mulu) ? mdt_pkg::LAT_MUL_FULL  :
	                 is_emul            ? mdt_pkg::LAT_EMUL_FULL :
	                 is_divs            ? mdt_pkg::LAT_DIVS      :
	                                      mdt_pkg::LAT_DIV;

	assign tpm_sel = mul_short          ? mdt_pkg::TPM_MUL_SHORT :
	                 (is_muls||is_mulu) ? mdt_pkg::TPM_MUL_FULL  :
	                 is_emul            ? mdt_pkg::TPM_EMUL_FULL :
	                 is_divs            ? mdt_pkg::TP_DIVS       :
	                                      mdt_pkg::TP_DIV;

	// overlap dropped with mask flag clear, except full unsigned multiply and divides
	assign tpf_sel = mul_short ? mdt_pkg::TPF_MUL_SHORT :
	                 is_muls   ? mdt_pkg::TPF_MULS_FULL :
	                 is_mulu   ? mdt_pkg::TPF_MULU_FULL :
	                 is_emul   ? mdt_pkg::TPF_EMUL_FULL :
	                 is_divs   ? mdt_pkg::TP_DIVS       :
	                             mdt_pkg::TP_DIV;

	assign tp_sel = overflow_mask_flag_in ? tpm_sel : tpf_sel;

	////////////////////////////////////////////////////////////////////////
	// throughput counter and busy

	logic [mdt_pkg::CNT_W-1:0] rate_cnt_r;
	wire  [mdt_pkg::CNT_W-1:0] rate_cnt_nxt;

	// next accept exactly tp clocks after issue
	assign rate_cnt_nxt = accept ? tp_sel - mdt_pkg::CNT_ONE :
	                      (rate_cnt_r != mdt_pkg::CNT_ZERO)
	                      ? rate_cnt_r - mdt_pkg::CNT_ONE : mdt_pkg::CNT_ZERO;

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			rate_cnt_r <= mdt_pkg::CNT_ZERO;
			busy_out   <= 1'b0;
		end else begin
			rate_cnt_r <= rate_cnt_nxt;
			busy_out   <= rate_cnt_nxt != mdt_pkg::CNT_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result slots

	mdt_pkg::mdt_slot_t   slot_r [mdt_pkg::SLOT_N];
	mdt_pkg::mdt_result_t new_res;
	wire  [mdt_pkg::SLOT_N-1:0] emit;
	wire                        free_idx;
	mdt_pkg::mdt_result_t       result_nxt;

	assign new_res  = '{valid: 1'b1, dest: issue_in.dest, hi: ar_hi,
	                    lo: ar_lo, overflow: ar_ovf, div_zero: ar_dz};
	assign free_idx = slot_r[0].busy;

	genvar gs;
	generate
		for (gs = 0; gs < mdt_pkg::SLOT_N; gs = gs + 1) begin : g_slot
			assign emit[gs] = slot_r[gs].busy
			               && (slot_r[gs].cnt == mdt_pkg::CNT_ONE);
			always_ff @(posedge clock_in or posedge reset_in) begin
				if (reset_in) begin
					slot_r[gs] <= '0;
				end else if (accept && (free_idx == 1'(gs))) begin
					slot_r[gs].busy <= 1'b1;
					slot_r[gs].cnt  <= lat_sel - mdt_pkg::CNT_ONE;
					slot_r[gs].res  <= new_res;
				end else if (emit[gs]) begin
					slot_r[gs].busy <= 1'b0;
				end else if (slot_r[gs].busy) begin
					slot_r[gs].cnt <= slot_r[gs].cnt - mdt_pkg::CNT_ONE;
				end
			end
		end
	endgenerate

	// result appears latency clocks after issue
	assign result_nxt = emit[0] ? slot_r[0].res :
	                    emit[1] ? slot_r[1].res : '0;

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			result_out <= '0;
		end else begin
			result_out <= result_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// destination scoreboard

	wire [31:0] sb_set;
	wire [31:0] sb_clr;

	genvar gr;
	generate
		for (gr = 0; gr < mdt_pkg::REG_N; gr = gr + 1) begin : g_sb
			assign sb_set[gr] = accept && (issue_in.dest == 5'(gr));
			assign sb_clr[gr] = result_nxt.valid && (result_nxt.dest == 5'(gr));
			// lock set at issue wins over release
			always_ff @(posedge clock_in or posedge reset_in) begin
				if (reset_in) begin
					scoreboard_out[gr] <= 1'b0;
				end else begin
					scoreboard_out[gr] <= sb_set[gr]
					                   || (scoreboard_out[gr] && !sb_clr[gr]);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);

	sequence s_take_mulu_full;
		accept && is_mulu && !ar_short;
	endsequence

	sequence s_take_divs;
		accept && is_divs;
	endsequence

	a_mulu_latency: assert property (
		s_take_mulu_full |-> ##5 (result_out.valid
		&& result_out.dest == $past(issue_in.dest, 5)))
		else $error("full unsigned multiply result not at fifth clock");

	a_mulu_value: assert property (
		s_take_mulu_full |-> ##5 (result_out.lo
		== 32'($past(first_operand_bus_in, 5)
		* $past(second_operand_bus_in, 5))))
		else $error("unsigned multiply product wrong");

	a_short_latency: assert property (
		accept && is_mul && ar_short |-> ##3 result_out.valid)
		else $error("short multiply result not at third clock");

	a_divs_latency: assert property (
		s_take_divs |-> ##37 result_out.valid)
		else $error("signed divide result not at clock 37");

	a_divs_rate: assert property (
		s_take_divs |-> ##35 busy_out ##1 !busy_out)
		else $error("signed divide throughput not 36");

	a_masked_rate: assert property (
		s_take_mulu_full and overflow_mask_flag_in
		|=> busy_out [*3] ##1 !busy_out)
		else $error("masked full multiply rate not four");

	a_unmasked_rate: assert property (
		accept && is_muls && !ar_short && !overflow_mask_flag_in
		|=> busy_out [*4] ##1 !busy_out)
		else $error("unmasked signed multiply rate not five");

	a_pipe_overlap: assert property (
		(s_take_mulu_full and overflow_mask_flag_in) ##4 accept
		|-> ##1 result_out.valid)
		else $error("first result not one clock after next issue");

	a_lock_set: assert property (
		accept |=> scoreboard_out[$past(issue_in.dest)])
		else $error("destination not locked after issue");

	a_lock_release: assert property (
		result_out.valid
		&& !($past(accept) && $past(issue_in.dest) == result_out.dest)
		|-> !scoreboard_out[result_out.dest])
		else $error("destination still locked when result written");

endmodule

// file: tb/mdt_sched_model.sv
`timescale 1ns/1ps

// scheduler and register file standing in front of the unit
module mdt_sched_model (
	input  wire logic                  clock_in,
	input  wire logic                  busy_in,
	input  wire mdt_pkg::mdt_result_t  result_in,
	output mdt_pkg::mdt_issue_t        issue_out,
	output logic [31:0]                first_out,
	output logic [31:0]                second_out,
	output logic [31:0]                high_out,
	output logic                       mask_out
);
	int          cyc = 0;
	int          res_cyc [32];
	logic [65:0] rf [32];

	initial begin
		issue_out = '0;
		first_out = 32'h0;
		second_out = 32'h0;
		high_out = 32'h0;
		mask_out = 1'b1;
	end

	//////////////////////////////////////////////////////////////////////
	// register updated when the result returns
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (result_in.valid === 1'b1) begin
			res_cyc[result_in.dest] <= cyc;
			rf[result_in.dest] <= {result_in.overflow, result_in.div_zero,
				result_in.hi, result_in.lo};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// request held until taken, issue clocks spent
	task automatic send(input mdt_pkg::mdt_op_t op, input logic [4:0] d,
			input logic [31:0] a, b, h, input logic m, output int take);
		int cost;
		cost = (op == mdt_pkg::OP_DIVS) ? mdt_pkg::ISSUE_DIVS :
			(op >= mdt_pkg::OP_DIVU) ? mdt_pkg::ISSUE_DIV : mdt_pkg::ISSUE_MUL;
		issue_out = {1'b1, op, d};
		first_out = a;
		second_out = b;
		high_out = h;
		mask_out = m;
		while (busy_in !== 1'b0) begin
			@(posedge clock_in);
			#1;
		end
		take = cyc;
		@(posedge clock_in);
		#1;
		issue_out.valid = 1'b0;
		first_out = ~a;
		second_out = ~b;
		high_out = ~h;
		repeat (cost - 1) @(posedge clock_in);
		#1;
	endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic                 clock_in = 1'b0;
	logic                 reset_in = 1'b1;
	mdt_pkg::mdt_issue_t  issue;
	mdt_pkg::mdt_result_t res;
	logic [31:0]          opa;
	logic [31:0]          opb;
	logic [31:0]          oph;
	logic [31:0]          sb;
	logic                 mask;
	logic                 busy;
	int                   fail_count = 0;
	int                   n_compared = 0;

	always #25 clock_in = ~clock_in;

	mdt_unit dut (
		.clock_in              (clock_in),
		.reset_in              (reset_in),
		.issue_in              (issue),
		.first_operand_bus_in  (opa),
		.second_operand_bus_in (opb),
		.high_operand_bus_in   (oph),
		.overflow_mask_flag_in (mask),
		.result_out            (res),
		.busy_out              (busy),
		.scoreboard_out        (sb)
	);

	mdt_sched_model sched (
		.clock_in   (clock_in),
		.busy_in    (busy),
		.result_in  (res),
		.issue_out  (issue),
		.first_out  (opa),
		.second_out (opb),
		.high_out   (oph),
		.mask_out   (mask)
	);

	//////////////////////////////////////////////////////////////////////
	task automatic check(input logic [65:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// expected {overflow, div_zero, hi, lo}
	function automatic logic [65:0] expect_val(input mdt_pkg::mdt_op_t op,
			input logic [31:0] a, b, h);
		logic [63:0] w;
		logic [63:0] p;
		logic [63:0] u;
		logic [31:0] r;
		logic        ov;
		w = 64'h0;
		p = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
		u = {32'h0, a} * {32'h0, b};
		r = $signed(a) % $signed(b);
		ov = (op == mdt_pkg::OP_MULS && p[63:31] != {33{p[31]}}) ||
			(op == mdt_pkg::OP_MULU && u[63:32] != 32'h0);
		case (op)
			mdt_pkg::OP_MULS, mdt_pkg::OP_MULU: w[31:0] = u[31:0];
			mdt_pkg::OP_EMUL: w = u;
			mdt_pkg::OP_DIVS: w[31:0] = $signed(a) / $signed(b);
			mdt_pkg::OP_DIVU: w[31:0] = a / b;
			mdt_pkg::OP_EDIV: w = {32'({h, a} % {32'h0, b}),
				32'({h, a} / {32'h0, b})};
			mdt_pkg::OP_REMS: w[31:0] = r;
			mdt_pkg::OP_REMU: w[31:0] = a % b;
			default: w[31:0] = (r != 0 && r[31] != b[31]) ? r + b : r;
		endcase
		return {ov, 1'b0, w};
	endfunction

	// two like operations back to back, second with swapped operands
	task automatic pair(input mdt_pkg::mdt_op_t op, input logic [31:0] a, b,
			input logic m, input int lat, tp);
		int         t0;
		int         t1;
		logic [4:0] d;
		d = {op, 1'b0};
		sched.send(op, d, a, b, 32'h3, m, t0);
		check(66'(sb[d]), 66'h1);
		sched.send(op, d + 5'h1, b, a, 32'h3, m, t1);
		repeat (40) @(posedge clock_in);
		#1;
		check(66'(t1 - t0), 66'(tp));
		check(66'(sched.res_cyc[d] - t0), 66'(lat));
		check(66'(sched.res_cyc[d + 5'h1] - t1), 66'(lat));
		check(sched.rf[d], expect_val(op, a, b, 32'h3));
		check(sched.rf[d + 5'h1], expect_val(op, b, a, 32'h3));
		check(66'(sb[d]), 66'h0);
	endtask

	//////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check(66'({res.valid, res.dest, res.overflow, res.div_zero, busy, sb}),
			66'h0);
		check(66'({res.hi, res.lo}), 66'h0);
		$display("test reset done");
	endtask

	task automatic t_mul_full;
		pair(mdt_pkg::OP_MULU, 32'h00010000, 32'h00030000, 1'b1, 5, 4);
		pair(mdt_pkg::OP_MULU, 32'h00010000, 32'h00030000, 1'b0, 5, 4);
		pair(mdt_pkg::OP_MULS, 32'h00008000, 32'h00008000, 1'b1, 5, 4);
		pair(mdt_pkg::OP_MULS, 32'h00008000, 32'h00008000, 1'b0, 5, 5);
		pair(mdt_pkg::OP_EMUL, 32'h00012345, 32'hFEDC0001, 1'b1, 6, 5);
		pair(mdt_pkg::OP_EMUL, 32'h00012345, 32'hFEDC0001, 1'b0, 6, 6);
		$display("test full multiply done");
	endtask

	task automatic t_mul_short;
		pair(mdt_pkg::OP_MULS, 32'hFFFF8000, 32'h00123456, 1'b1, 3, 2);
		pair(mdt_pkg::OP_MULS, 32'hFFFF8000, 32'h00123456, 1'b0, 3, 3);
		pair(mdt_pkg::OP_MULU, 32'h0000FFFF, 32'h12345678, 1'b1, 3, 2);
		pair(mdt_pkg::OP_MULU, 32'h0000FFFF, 32'h12345678, 1'b0, 3, 3);
		pair(mdt_pkg::OP_EMUL, 32'h0000FFFF, 32'h9ABCDEF0, 1'b1, 3, 2);
		pair(mdt_pkg::OP_EMUL, 32'h0000FFFF, 32'h9ABCDEF0, 1'b0, 3, 3);
		$display("test short multiply done");
	endtask

	task automatic t_divide;
		pair(mdt_pkg::OP_DIVS, 32'hFFFFF9C3, 32'h00000007, 1'b1, 37, 36);
		pair(mdt_pkg::OP_DIVS, 32'hFFFFF9C3, 32'h00000007, 1'b0, 37, 36);
		pair(mdt_pkg::OP_DIVU, 32'hFFFFF9C3, 32'h00000007, 1'b0, 36, 35);
		pair(mdt_pkg::OP_EDIV, 32'hFFFFF9C3, 32'h00000007, 1'b1, 36, 35);
		pair(mdt_pkg::OP_REMS, 32'hFFFFF9C3, 32'h00000007, 1'b1, 36, 35);
		pair(mdt_pkg::OP_REMU, 32'hFFFFF9C3, 32'h00000007, 1'b1, 36, 35);
		pair(mdt_pkg::OP_MODS, 32'hFFFFF9C3, 32'h00000007, 1'b1, 36, 35);
		$display("test divide done");
	endtask

	task automatic t_div_zero;
		int t0;
		int t1;
		sched.send(mdt_pkg::OP_DIVU, 5'h1F, 32'h12345678, 32'h0, 32'h0, 1'b1,
			t0);
		sched.send(mdt_pkg::OP_DIVS, 5'h1E, 32'h80000000, 32'hFFFFFFFF, 32'h0,
			1'b1, t1);
		repeat (40) @(posedge clock_in);
		#1;
		check(66'(t1 - t0), 66'(35));
		check(sched.rf[31], {2'b01, 32'h0, 32'h12345678});
		check(sched.rf[30], {2'b10, 32'h0, 32'h80000000});
		$display("test divide by zero done");
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		#250000;
		fail_count++;
		results();
	end

	initial begin
		repeat (4) @(posedge clock_in);
		#1;
		reset_in = 1'b0;
		t_reset();
		t_mul_full();
		t_mul_short();
		t_divide();
		t_div_zero();
		results();
	end
endmodule
